// *** lpm_ctrl.sv ***
// Low-power mode controller: halt, idle, wake-up and bus clock divider.
`timescale 1ns/1ps
module lpm_ctrl
   import lpm_pkg::*;
#(
   // Stabilization count; shorten in simulation.
   parameter int unsigned STAB_CYCLES = OSC_STAB_CYC
)
(
   // Clock and reset.
   input wire logic CLK,
   input wire logic RESET_N,
   // Processor entry requests, one-cycle pulses.
   input wire logic HALT_REQ,
   input wire logic IDLE_REQ,
   // Mask option that turns the halt instruction into a no-op.
   input wire logic HALT_DISABLE,
   // External interrupt pin, asynchronous.
   input wire logic EXT_IRQ_PIN,
   // Enabled interrupt requests from on-chip peripherals.
   input wire logic CORE_TIMER_IRQ,
   input wire logic PROG_TIMER_IRQ,
   input wire logic SERIAL_IRQ,
   // Core timer interrupt bits, software writes.
   input wire lpm_ctimer_irq_t CTIRQ_WR_DATA,
   input wire logic CTIRQ_WR,
   // Core timer events that set the flags.
   input wire logic CT_OVF_EVENT,
   input wire logic CT_TICK_EVENT,
   // Interrupt mask bit, software set and clear.
   input wire logic IMASK_SET,
   input wire logic IMASK_CLR,
   // Outputs.
   output lpm_state_t POWER_STATE,
   output logic OSC_RUN,
   output logic BUS_CLK_EN,
   output logic CPU_RUN,
   output logic TIMERS_RUN,
   output logic WATCHDOG_RUN,
   output lpm_ctimer_irq_t CTIRQ,
   output logic [PRESC_W-1:0] PRESCALER,
   output logic IMASK,
   output logic HALT_NOP
);
   // ==========================================================
   // Declarations
   // ==========================================================
   // Synchronised external interrupt.
   logic ext_irq_s;
   // Power state register.
   lpm_state_t state_ff;
   lpm_state_t nxt_state;
   // Stabilization counter.
   logic [STAB_W-1:0] stab_ff;
   logic [STAB_W-1:0] nxt_stab;
   // Divide-by-two phase of the oscillator.
   logic div_ff;
   logic nxt_div;
   // Core timer interrupt bits, prescaler and mask.
   lpm_ctimer_irq_t ctirq_ff;
   lpm_ctimer_irq_t nxt_ctirq;
   logic [PRESC_W-1:0] presc_ff;
   logic [PRESC_W-1:0] nxt_presc;
   logic imask_ff;
   logic nxt_imask;
   // Halt no-op indication, one cycle.
   logic nop_ff;
   logic nxt_nop;
   // Entry strobes.
   logic halt_go;
   logic idle_go;

   // Full-width stabilization limit, cast once.
   localparam logic [STAB_W-1:0] STAB_LAST = STAB_W'(STAB_CYCLES - 1);

   // Wake source for idle: any enabled peripheral or external interrupt.
   function automatic logic idle_wake(input lpm_wake_t w);
      idle_wake = w.ext_irq | w.core_timer_irq | w.prog_timer_irq | w.serial_irq;
   endfunction : idle_wake

   // ==========================================================
   // External interrupt synchroniser
   // ==========================================================
   lpm_sync u_ext_sync (
      .CLK(CLK),
      .RESET_N(RESET_N),
      .din(EXT_IRQ_PIN),
      .dout(ext_irq_s)
   );

   // ==========================================================
   // Power state machine
   // ==========================================================
   // Entry is only taken from run; a disabled halt is reported as a no-op.
   always_comb begin
      halt_go = (state_ff == LPM_RUN) && HALT_REQ && !HALT_DISABLE;
      idle_go = (state_ff == LPM_RUN) && IDLE_REQ && !HALT_REQ;
      nxt_state = state_ff;
      nxt_stab = stab_ff;
      nxt_nop = (state_ff == LPM_RUN) && HALT_REQ && HALT_DISABLE;
      case (state_ff)
         LPM_RUN: begin
            if (halt_go) begin
               nxt_state = LPM_HALT;
            end else if (idle_go) begin
               nxt_state = LPM_IDLE;
            end
         end
         LPM_IDLE: begin
            if (idle_wake(lpm_wake_t'{ext_irq_s, CORE_TIMER_IRQ, PROG_TIMER_IRQ, SERIAL_IRQ})) begin
               nxt_state = LPM_RUN;
            end
         end
         LPM_HALT: begin
            if (ext_irq_s) begin
               nxt_state = LPM_STAB;
               nxt_stab = '0;
            end
         end
         LPM_STAB: begin
            if (stab_ff >= STAB_LAST) begin
               nxt_state = LPM_RUN;
            end else begin
               nxt_stab = stab_ff + STAB_W'(1);
            end
         end
         default: begin
            nxt_state = LPM_RUN;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state_ff <= LPM_RUN;
         stab_ff <= '0;
         nop_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         stab_ff <= nxt_stab;
         nop_ff <= nxt_nop;
      end
   end

   // ==========================================================
   // Bus clock divider
   // ==========================================================
   // divide by two
   always_comb begin
      nxt_div = OSC_RUN ? ~div_ff : div_ff;
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         div_ff <= 1'b0;
      end else begin
         div_ff <= nxt_div;
      end
   end

   // ==========================================================
   // Core timer bits, prescaler and interrupt mask
   // ==========================================================
   // Events set flags and win over a software clear; halt entry clears all.
   always_comb begin
      nxt_ctirq = ctirq_ff;
      nxt_presc = presc_ff;
      nxt_imask = imask_ff;
      if (CTIRQ_WR) begin
         nxt_ctirq = CTIRQ_WR_DATA;
      end
      if (CT_OVF_EVENT) begin
         nxt_ctirq.core_timer_overflow_flag = 1'b1;
      end
      if (CT_TICK_EVENT) begin
         nxt_ctirq.periodic_tick_flag = 1'b1;
      end
      if (TIMERS_RUN) begin
         nxt_presc = presc_ff + PRESC_W'(1);
      end
      if (IMASK_SET) begin
         nxt_imask = 1'b1;
      end else if (IMASK_CLR) begin
         nxt_imask = 1'b0;
      end
      if (halt_go) begin
         nxt_ctirq = CTIRQ_RST;
         nxt_presc = PRESC_RST;
         nxt_imask = 1'b0;
      end else if (idle_go) begin
         nxt_imask = 1'b0;
      end
      if (state_ff == LPM_HALT) begin
         nxt_ctirq = ctirq_ff;
         nxt_presc = presc_ff;
      end
   end

   // Mask reads set after reset, as the processor does.
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ctirq_ff <= CTIRQ_RST;
         presc_ff <= PRESC_RST;
         imask_ff <= 1'b1;
      end else begin
         ctirq_ff <= nxt_ctirq;
         presc_ff <= nxt_presc;
         imask_ff <= nxt_imask;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   // oscillator off in halt
   assign OSC_RUN = (state_ff != LPM_HALT);
   assign BUS_CLK_EN = div_ff;
   assign CPU_RUN = (state_ff == LPM_RUN);
   assign TIMERS_RUN = (state_ff == LPM_RUN) || (state_ff == LPM_IDLE);
   assign WATCHDOG_RUN = TIMERS_RUN;
   assign POWER_STATE = state_ff;
   assign CTIRQ = ctirq_ff;
   assign PRESCALER = presc_ff;
   assign IMASK = imask_ff;
   assign HALT_NOP = nop_ff;
endmodule : lpm_ctrl

// *** lpm_pkg.sv ***
// Package of constants and carrier types for the low-power mode controller.
package lpm_pkg;
   // ==========================================================
   // Timing constants
   // ==========================================================
   // Clock period in picoseconds (40 MHz).
   localparam int unsigned CLK_PERIOD_PS = 25000;
   // Oscillator stabilization time after halt wake-up, in microseconds.
   localparam int unsigned OSC_STAB_US = 100;
   // Stabilization delay in cycles, rounded up (least time).
   localparam int unsigned OSC_STAB_CYC = (OSC_STAB_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Width of the stabilization counter.
   localparam int unsigned STAB_W = 16;
   // Core timer prescaler width and its reset value.
   localparam int unsigned PRESC_W = 8;
   localparam logic [7:0] PRESC_RST = 8'h00;
   // Input synchroniser depth.
   localparam int unsigned SYNC_DEPTH = 3;

   // ==========================================================
   // Types
   // ==========================================================
   // Power state of the device.
   typedef enum logic [2:0] {
      LPM_RUN,
      LPM_IDLE,
      LPM_HALT,
      LPM_STAB
   } lpm_state_t;

   // Core timer interrupt bits that hardware clears on halt entry.
   typedef struct packed {
      logic core_timer_overflow_flag;
      logic periodic_tick_flag;
      logic core_timer_overflow_irq_en;
      logic periodic_tick_irq_en;
   } lpm_ctimer_irq_t;
   localparam lpm_ctimer_irq_t CTIRQ_RST = '{1'b0, 1'b0, 1'b0, 1'b0};

   // Wake sources into the controller.
   typedef struct packed {
      logic ext_irq;
      logic core_timer_irq;
      logic prog_timer_irq;
      logic serial_irq;
   } lpm_wake_t;
endpackage : lpm_pkg

// *** lpm_sync.sv ***
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ps
module lpm_sync
   import lpm_pkg::*;
(
   // Clock and reset.
   input wire logic CLK,
   input wire logic RESET_N,
   // Asynchronous input and filtered result.
   input wire logic din,
   output logic dout
);
   // ==========================================================
   // Synchroniser chain
   // ==========================================================
   // Chain of three flops; stage 0 feeds only stage 1.
   logic [SYNC_DEPTH-1:0] chain_ff;
   logic [SYNC_DEPTH-1:0] nxt_chain;
   // Filtered output register.
   logic out_ff;
   logic nxt_out;

   // Shift the chain and update only when the last two stages agree.
   always_comb begin
      nxt_chain = {chain_ff[SYNC_DEPTH-2:0], din};
      nxt_out = out_ff;
      if (chain_ff[1] == chain_ff[2]) begin
         nxt_out = chain_ff[2];
      end
   end

   // Register the chain and filtered value.
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         chain_ff <= '0;
         out_ff <= 1'b0;
      end else begin
         chain_ff <= nxt_chain;
         out_ff <= nxt_out;
      end
   end

   assign dout = out_ff;
endmodule : lpm_sync

// *** lpm_ctrl_monitor.sv ***
// Port checker for the low-power mode controller.
`timescale 1ns/1ps
module lpm_ctrl_monitor
   import lpm_pkg::*;
#(
   parameter int unsigned STAB_CYCLES = 4
)
(
   // Clock, reset and requests.
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic HALT_REQ,
   input wire logic IDLE_REQ,
   input wire logic HALT_DISABLE,
   input wire logic EXT_IRQ_PIN,
   input wire logic CORE_TIMER_IRQ,
   input wire logic PROG_TIMER_IRQ,
   input wire logic SERIAL_IRQ,
   // Observed outputs.
   input wire lpm_state_t POWER_STATE,
   input wire logic OSC_RUN,
   input wire logic BUS_CLK_EN,
   input wire logic CPU_RUN,
   input wire logic TIMERS_RUN,
   input wire logic WATCHDOG_RUN,
   input wire lpm_ctimer_irq_t CTIRQ,
   input wire logic [PRESC_W-1:0] PRESCALER,
   input wire logic IMASK,
   input wire logic HALT_NOP
);
   // ==========================================================
   // Helper counter and properties
   // ==========================================================
   // Counts cycles spent settling, since a repetition cannot take a parameter.
   logic [15:0] stab_cnt_ff;
   logic [15:0] nxt_stab_cnt;
   always_comb nxt_stab_cnt = (POWER_STATE == LPM_STAB) ? stab_cnt_ff + 16'h0001 : 16'h0000;
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         stab_cnt_ff <= 16'h0000;
      end else begin
         stab_cnt_ff <= nxt_stab_cnt;
      end
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   // A halt instruction taken while running.
   sequence s_run_halt;
      POWER_STATE == LPM_RUN && HALT_REQ;
   endsequence
   a_halt_entry: assert property (s_run_halt ##0 !HALT_DISABLE |=> POWER_STATE == LPM_HALT
      && CTIRQ == CTIRQ_RST && PRESCALER == PRESC_RST && !IMASK) else $error("halt entry wrong");
   a_halt_nop: assert property (s_run_halt ##0 HALT_DISABLE |=> HALT_NOP && POWER_STATE == LPM_RUN)
      else $error("disabled halt not a no-op");
   a_halt_stop: assert property (POWER_STATE == LPM_HALT |-> !OSC_RUN && !TIMERS_RUN && !WATCHDOG_RUN)
      else $error("clocks run in halt");
   a_bus_div: assert property (OSC_RUN ##1 OSC_RUN |-> BUS_CLK_EN != $past(BUS_CLK_EN))
      else $error("bus clock enable not toggling");
   a_halt_keep: assert property (POWER_STATE == LPM_HALT |=> $stable(CTIRQ) && $stable(PRESCALER))
      else $error("state changed in halt");
   a_halt_only_ext: assert property ((!EXT_IRQ_PIN) [*5] ##0 POWER_STATE == LPM_HALT |=> POWER_STATE == LPM_HALT)
      else $error("halt left without external interrupt");
   a_halt_wake: assert property ($rose(EXT_IRQ_PIN) && POWER_STATE == LPM_HALT |-> ##[1:6] POWER_STATE == LPM_STAB)
      else $error("halt not woken");
   a_stab_len: assert property ($past(POWER_STATE) == LPM_STAB && POWER_STATE != LPM_STAB |->
      POWER_STATE == LPM_RUN && stab_cnt_ff == STAB_CYCLES) else $error("settling time wrong");
   a_idle_entry: assert property (POWER_STATE == LPM_RUN && IDLE_REQ && !HALT_REQ |=> POWER_STATE == LPM_IDLE
      && !IMASK && !CPU_RUN && TIMERS_RUN) else $error("idle entry wrong");
   a_idle_exit: assert property (POWER_STATE == LPM_IDLE && (CORE_TIMER_IRQ || PROG_TIMER_IRQ || SERIAL_IRQ)
      |=> POWER_STATE == LPM_RUN) else $error("idle not left");
endmodule : lpm_ctrl_monitor
bind lpm_ctrl lpm_ctrl_monitor #(.STAB_CYCLES(STAB_CYCLES)) u_mon (.*);

// *** lpm_periph_model.sv ***
// Model of the interrupting peripherals beside the controller.
`timescale 1ns/1ps
module lpm_periph_model
   import lpm_pkg::*;
(
   // Clock, commanded sources and their start delay.
   input wire logic clk,
   input wire lpm_wake_t want,
   input wire logic [3:0] dly,
   // Request levels towards the controller.
   output lpm_wake_t irq
);
   // ==========================================================
   // Request timing
   // ==========================================================
   int cnt = 0;
   initial irq = '0;
   // Level requests stay up until withdrawn, so slow and prompt sources both occur.
   always @(negedge clk) begin
      if (want == 4'h0) begin
         irq <= '0;
         cnt <= 0;
      end else if (cnt >= dly) begin
         irq <= want;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule : lpm_periph_model

// *** testbench.sv ***
// Self-checking testbench of the low-power mode controller.
`timescale 1ns/1ps
module testbench;
   import lpm_pkg::*;
   // ==========================================================
   // Stimulus, model and checks
   // ==========================================================
   logic CLK, RESET_N, HALT_REQ, IDLE_REQ, HALT_DISABLE, CTIRQ_WR, CT_OVF_EVENT, CT_TICK_EVENT, IMASK_SET, IMASK_CLR;
   logic OSC_RUN, BUS_CLK_EN, CPU_RUN, TIMERS_RUN, WATCHDOG_RUN, IMASK, HALT_NOP, b;
   lpm_ctimer_irq_t CTIRQ_WR_DATA, CTIRQ, exp_ct;
   lpm_state_t POWER_STATE, exp_st;
   logic [7:0] PRESCALER;
   lpm_wake_t want, irq;
   logic [3:0] dly;
   logic exp_imask;
   int bad_count = 0, num_checks = 0, n, rnd;
   initial begin
      CLK = 0;
      forever #12.5 CLK = ~CLK;
   end
   lpm_ctrl #(.STAB_CYCLES(4)) u_lpm_ctrl (.CLK(CLK), .RESET_N(RESET_N), .HALT_REQ(HALT_REQ), .IDLE_REQ(IDLE_REQ),
      .HALT_DISABLE(HALT_DISABLE), .EXT_IRQ_PIN(irq.ext_irq), .CORE_TIMER_IRQ(irq.core_timer_irq),
      .PROG_TIMER_IRQ(irq.prog_timer_irq), .SERIAL_IRQ(irq.serial_irq), .CTIRQ_WR_DATA(CTIRQ_WR_DATA),
      .CTIRQ_WR(CTIRQ_WR), .CT_OVF_EVENT(CT_OVF_EVENT), .CT_TICK_EVENT(CT_TICK_EVENT), .IMASK_SET(IMASK_SET),
      .IMASK_CLR(IMASK_CLR), .POWER_STATE(POWER_STATE), .OSC_RUN(OSC_RUN), .BUS_CLK_EN(BUS_CLK_EN),
      .CPU_RUN(CPU_RUN), .TIMERS_RUN(TIMERS_RUN), .WATCHDOG_RUN(WATCHDOG_RUN), .CTIRQ(CTIRQ),
      .PRESCALER(PRESCALER), .IMASK(IMASK), .HALT_NOP(HALT_NOP));
   lpm_periph_model u_lpm_periph_model (.clk(CLK), .want(want), .dly(dly), .irq(irq));
   task automatic wrap_up();
      $display("checks %0d errors %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : wrap_up
   task automatic chk_v(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL %0t value %0h expected %0h", $time, got, exp);
      end
   endtask : chk_v
   task automatic chk_st(input lpm_state_t got, input lpm_state_t exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL %0t state %0d expected %0d", $time, got, exp);
      end
   endtask : chk_st
   // Model state against design outputs.
   task automatic cmp_all();
      chk_st(POWER_STATE, exp_st);
      chk_v(IMASK, exp_imask);
      chk_v(CTIRQ, exp_ct);
   endtask : cmp_all
   // Bounded wait on the power state; a miss ends the run.
   task automatic wait_st(input lpm_state_t s);
      n = 0;
      while (POWER_STATE !== s) begin
         @(negedge CLK);
         n++;
         if (n > 60) begin
            bad_count++;
            $display("FAIL %0t wait timed out", $time);
            wrap_up();
         end
      end
   endtask : wait_st
   task automatic req(input logic h, input logic i);
      @(negedge CLK);
      HALT_REQ = h;
      IDLE_REQ = i;
      @(negedge CLK);
      HALT_REQ = 0;
      IDLE_REQ = 0;
   endtask : req
   initial begin
      {HALT_REQ, IDLE_REQ, HALT_DISABLE, CTIRQ_WR, CT_OVF_EVENT, CT_TICK_EVENT, IMASK_SET, IMASK_CLR} = '0;
      CTIRQ_WR_DATA = '0;
      want = '0;
      dly = '0;
      RESET_N = 0;
      rnd = $urandom(32'hefc05e1b);
      repeat (6) @(negedge CLK);
      RESET_N = 1;
      exp_st = LPM_RUN;
      exp_imask = 1'b1;
      exp_ct = CTIRQ_RST;
      cmp_all();
      b = BUS_CLK_EN;
      @(negedge CLK);
      // Logical not keeps the expected toggle one bit wide.
      chk_v(BUS_CLK_EN, !b);
      HALT_DISABLE = 1;
      req(1, 0);
      chk_v(HALT_NOP, 1);
      cmp_all();
      HALT_DISABLE = 0;
      exp_ct = lpm_ctimer_irq_t'($urandom_range(15, 1));
      CTIRQ_WR_DATA = exp_ct;
      // An overflow event in the write cycle must win over the written flag.
      CTIRQ_WR = 1;
      CT_OVF_EVENT = 1;
      IMASK_CLR = 1;
      @(negedge CLK);
      CTIRQ_WR = 0;
      CT_OVF_EVENT = 0;
      IMASK_SET = 1;
      exp_ct.core_timer_overflow_flag = 1'b1;
      exp_imask = 1'b0;
      cmp_all();
      // Set and clear of the mask together: set wins.
      @(negedge CLK);
      IMASK_SET = 0;
      IMASK_CLR = 0;
      exp_imask = 1'b1;
      cmp_all();
      req(1, 0);
      exp_st = LPM_HALT;
      exp_imask = 1'b0;
      exp_ct = CTIRQ_RST;
      cmp_all();
      chk_v(PRESCALER, PRESC_RST);
      chk_v({OSC_RUN, TIMERS_RUN, WATCHDOG_RUN, CPU_RUN}, 0);
      // Timer and serial requests must leave the halted device asleep.
      want = 4'h7;
      repeat (10) @(negedge CLK);
      cmp_all();
      dly = 4'($urandom_range(6, 0));
      want = 4'h8;
      wait_st(LPM_STAB);
      chk_v({OSC_RUN, CPU_RUN}, 2);
      wait_st(LPM_RUN);
      chk_v(8'(n), 4);
      // Each wake source in turn ends idle, with a random source delay.
      for (int i = 0; i < 4; i++) begin
         want = '0;
         IMASK_SET = 1;
         repeat (5) @(negedge CLK);
         IMASK_SET = 0;
         req(0, 1);
         exp_st = LPM_IDLE;
         exp_imask = 1'b0;
         cmp_all();
         chk_v({CPU_RUN, TIMERS_RUN, WATCHDOG_RUN}, 3);
         dly = 4'($urandom_range(9, 0));
         want = lpm_wake_t'(4'h1 << i);
         wait_st(LPM_RUN);
         exp_st = LPM_RUN;
         cmp_all();
      end
      // A reset also ends halt; the pin is left low long enough to clear the synchroniser.
      want = '0;
      repeat (6) @(negedge CLK);
      req(1, 0);
      chk_st(POWER_STATE, LPM_HALT);
      RESET_N = 0;
      @(negedge CLK);
      RESET_N = 1;
      exp_st = LPM_RUN;
      exp_imask = 1'b1;
      exp_ct = CTIRQ_RST;
      cmp_all();
      wrap_up();
   end
endmodule : testbench
